// >>> hw/pia_irq_arbiter.sv
`default_nettype none
// Operation
// - every source above the fixed ones except source 20, whose field is reserved, gets one of three levels from the priority registers
// - fixed sources ignore the priority registers and keep a constant level
// - within a level the lowest numbered active source wins
// - core is told when a serviceable request exists and where to jump
// - normal vector is the table base joined with the vector number
// - core mask bits permit level at or above the mask value
// - level indication 00 idle or lowest soft, 11 for levels 2 and 3
// - level 2 winner matching a fast match uses the fast address
// - fast decision is made before the core fetches the vector
// - in wait or stop a pending request asks the clock unit to wake
// - only requests enabled before low power can wake the core
// - external requests are low level sensitive in wait and stop
// - initial program address is driven after reset
// - registers sit on the peripheral bus at base plus word offset
// - block leaves reset in functional mode
// - first priority register holds fields at 13-12 and 11-10, resets zero
// - debug fields: 00 off, 01 10 11 select levels 1 2 3
// - peripheral fields: 00 off, 01 10 11 select levels 0 1 2
// - reserved priority bits read zero and ignore writes
module pia_irq_arbiter (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // peripheral bus slave
  input  wire pia_pkg::pia_bus_t      bus_i,
  output logic [15:0]                 rdata_o,
  // interrupt sources
  input  wire logic [81:0]            irq_src_i,
  input  wire logic                   ext_irq_a_n_i,
  input  wire logic                   ext_irq_b_n_i,
  // processor core
  input  wire logic [1:0]             core_mask_i,
  input  wire logic                   core_ack_i,
  input  wire logic                   core_rti_i,
  output logic                        core_irq_o,
  output logic                        core_fast_o,
  output logic [20:0]                 core_vec_o,
  output logic                        boot_o,
  // system integration unit
  input  wire logic                   low_power_i,
  output logic                        wake_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]         prio_reg [pia_pkg::NUM_PRIO];
  logic [15:0]         vbase_reg;
  logic [15:0]         fmatch0_reg;
  logic [15:0]         fvlow0_reg;
  logic [15:0]         fvhigh0_reg;
  logic [15:0]         fmatch1_reg;
  logic [15:0]         fvlow1_reg;
  logic [15:0]         fvhigh1_reg;
  logic [1:0]          edge_sel_reg;
  logic [1:0]          ind_reg;
  logic [1:0]          pres_lvl_reg;
  logic [6:0]          pres_src_reg;
  logic                ext_a_prev_reg;
  logic                ext_b_prev_reg;
  logic                ext_a_lat_reg;
  logic                ext_b_lat_reg;
  logic [15:0]         rdata_reg;
  logic                irq_reg;
  logic                fast_reg;
  logic [20:0]         vec_reg;
  logic                wake_reg;
  logic                boot_reg;
  pia_pkg::pia_state_t state_reg;
  pia_pkg::pia_mode_t  mode_reg;

  // ----------------------------------------------------------------
  // address decode and write masks
  // ----------------------------------------------------------------
  wire        lowpwr     = (mode_reg == pia_pkg::MODE_LOWPWR);
  wire        is_prio    = (bus_i.addr <= pia_pkg::OFF_PRIO_LAST);
  wire        is_pend    = (bus_i.addr >= pia_pkg::OFF_PEND_FIRST) &&
                           (bus_i.addr <= pia_pkg::OFF_PEND_LAST);
  wire [3:0]  prio_idx   = bus_i.addr[3:0];
  wire [2:0]  pend_idx   = 3'(bus_i.addr - pia_pkg::OFF_PEND_FIRST);
  logic [15:0] prio_wmask;
  assign prio_wmask = (prio_idx == 4'h0) ? pia_pkg::PRIO0_MASK :
                      (prio_idx == 4'h1) ? pia_pkg::PRIO1_MASK :
                      (prio_idx == 4'h2) ? pia_pkg::PRIO2_MASK :
                                           pia_pkg::PRIO_MASK;
  wire [15:0] wmasked    = bus_i.wdata & prio_wmask;

  // ----------------------------------------------------------------
  // external request capture
  // ----------------------------------------------------------------
  wire ext_a_fall = ext_a_prev_reg & ~ext_irq_a_n_i;
  wire ext_b_fall = ext_b_prev_reg & ~ext_irq_b_n_i;
  wire ack_a      = core_ack_i && (pres_src_reg == 7'(pia_pkg::SRC_EXT_A));
  wire ack_b      = core_ack_i && (pres_src_reg == 7'(pia_pkg::SRC_EXT_B));
  // a new edge beats a clearing acknowledge in the same cycle
  wire ext_a_lat_next = ext_a_fall | (ext_a_lat_reg & ~ack_a);
  wire ext_b_lat_next = ext_b_fall | (ext_b_lat_reg & ~ack_b);
  // edge mode only while clocks run; low power forces level sensing
  wire ext_a_req = (edge_sel_reg[0] && !lowpwr) ? ext_a_lat_reg
                                                 : ~ext_irq_a_n_i;
  wire ext_b_req = (edge_sel_reg[1] && !lowpwr) ? ext_b_lat_reg
                                                 : ~ext_irq_b_n_i;

  logic [81:0] req;
  always_comb begin
    req                       = irq_src_i;
    req[pia_pkg::SRC_EXT_A]   = ext_a_req;
    req[pia_pkg::SRC_EXT_B]   = ext_b_req;
  end

  // ----------------------------------------------------------------
  // per source enable and level
  // ----------------------------------------------------------------
  logic [81:0] src_en;
  logic [1:0]  src_lvl [pia_pkg::NUM_SRC];
  logic [81:0] lvl_vec [4];

  for (genvar s = 0; s < pia_pkg::NUM_SRC; s++) begin : g_src
    if (s < pia_pkg::FIXED_SRC) begin : g_fixed
      // constant level, not reachable from software
      assign src_en[s]  = 1'b1;
      assign src_lvl[s] = (s == pia_pkg::SRC_SOFT_LOW) ? pia_pkg::LVL_SOFT
                                                       : pia_pkg::LVL_FIXED;
    end else if (s < pia_pkg::GEN_FIRST) begin : g_dbg
      localparam int IDX = s - pia_pkg::DBG_FIRST;
      localparam int RG  = (IDX < 2) ? 0 : 1;
      localparam int LSB = (IDX < 2) ? (12 - 2 * IDX) : (4 - 2 * (IDX - 2));
      wire [1:0] code = prio_reg[RG][LSB +: 2];
      assign src_en[s]  = (code != 2'h0);
      assign src_lvl[s] = code;
    end else begin : g_gen
      localparam int IDX = s - pia_pkg::GEN_FIRST;
      localparam int RG  = 2 + IDX / 8;
      localparam int LSB = 2 * (IDX % 8);
      wire [1:0] code = prio_reg[RG][LSB +: 2];
      assign src_en[s]  = (code != 2'h0);
      assign src_lvl[s] = code - 2'h1;
    end
    for (genvar l = 0; l < 4; l++) begin : g_lvl
      // request sorted into its programmed level
      assign lvl_vec[l][s] = req[s] & src_en[s] & (src_lvl[s] == 2'(l));
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  function automatic logic [6:0] first_set(input logic [81:0] v);
    logic [6:0] idx;
    idx = 7'h00;
    for (int i = pia_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 7'(i);
      end
    end
    return idx;
  endfunction

  wire [3:0] lvl_any = {|lvl_vec[3], |lvl_vec[2], |lvl_vec[1], |lvl_vec[0]};
  wire       have_any = |lvl_any;
  // highest level that holds a request
  wire [1:0] top_lvl = lvl_any[3] ? 2'h3 :
                       lvl_any[2] ? 2'h2 :
                       lvl_any[1] ? 2'h1 : 2'h0;
  wire [81:0] top_vec = lvl_vec[top_lvl];
  wire [6:0]  win_src = first_set(top_vec);
  wire        permit  = have_any && (top_lvl >= core_mask_i);

  // fast match is resolved here, ahead of the core's vector fetch
  wire fast0 = (top_lvl == pia_pkg::LVL_FAST) && (win_src == fmatch0_reg[6:0]);
  wire fast1 = (top_lvl == pia_pkg::LVL_FAST) && (win_src == fmatch1_reg[6:0]);
  wire [20:0] norm_addr = {vbase_reg[13:0], win_src};
  wire [20:0] fast_addr = fast0 ? {fvhigh0_reg[4:0], fvlow0_reg}
                                : {fvhigh1_reg[4:0], fvlow1_reg};
  wire        fast_hit  = fast0 | fast1;
  wire [20:0] vec_next  = (state_reg == pia_pkg::ST_BOOT) ? pia_pkg::INIT_ADDR :
                          (!permit) ? vec_reg :
                          fast_hit ? fast_addr : norm_addr;

  // wake on any source whose field was enabled before sleeping
  wire wake_next = lowpwr && have_any;

  // level indication encoding of the acknowledged level
  wire [1:0] ind_code = (pres_src_reg == 7'(pia_pkg::SRC_SOFT_LOW)) ? 2'h0 :
                        (pres_lvl_reg == 2'h0) ? 2'h1 :
                        (pres_lvl_reg == 2'h1) ? 2'h2 : 2'h3;
  wire [1:0] ind_next = core_ack_i ? ind_code :
                        core_rti_i ? 2'h0 : ind_reg;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [95:0] pend_all = {14'h0000, req};
  logic [15:0] rd_mux;
  always_comb begin
    if (is_prio) begin
      rd_mux = prio_reg[prio_idx];
    end else if (bus_i.addr == pia_pkg::OFF_VBASE) begin
      rd_mux = vbase_reg;
    end else if (bus_i.addr == pia_pkg::OFF_FMATCH0) begin
      rd_mux = fmatch0_reg;
    end else if (bus_i.addr == pia_pkg::OFF_FVLOW0) begin
      rd_mux = fvlow0_reg;
    end else if (bus_i.addr == pia_pkg::OFF_FVHIGH0) begin
      rd_mux = fvhigh0_reg;
    end else if (bus_i.addr == pia_pkg::OFF_FMATCH1) begin
      rd_mux = fmatch1_reg;
    end else if (bus_i.addr == pia_pkg::OFF_FVLOW1) begin
      rd_mux = fvlow1_reg;
    end else if (bus_i.addr == pia_pkg::OFF_FVHIGH1) begin
      rd_mux = fvhigh1_reg;
    end else if (is_pend) begin
      rd_mux = pend_all[16 * pend_idx +: 16];
    end else if (bus_i.addr == pia_pkg::OFF_CTRL) begin
      rd_mux = {12'h000, ind_reg, edge_sel_reg};
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // register file writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < pia_pkg::NUM_PRIO; i++) begin
        prio_reg[i] <= pia_pkg::REG_RST;
      end
      vbase_reg    <= pia_pkg::REG_RST;
      fmatch0_reg  <= pia_pkg::REG_RST;
      fvlow0_reg   <= pia_pkg::REG_RST;
      fvhigh0_reg  <= pia_pkg::REG_RST;
      fmatch1_reg  <= pia_pkg::REG_RST;
      fvlow1_reg   <= pia_pkg::REG_RST;
      fvhigh1_reg  <= pia_pkg::REG_RST;
      edge_sel_reg <= 2'h0;
    end else if (bus_i.wr) begin
      // word offset decode on the peripheral bus
      if (is_prio) begin
        prio_reg[prio_idx] <= wmasked;
      end else if (bus_i.addr == pia_pkg::OFF_VBASE) begin
        vbase_reg <= bus_i.wdata & pia_pkg::VBASE_MASK;
      end else if (bus_i.addr == pia_pkg::OFF_FMATCH0) begin
        fmatch0_reg <= bus_i.wdata & pia_pkg::FMATCH_MASK;
      end else if (bus_i.addr == pia_pkg::OFF_FVLOW0) begin
        fvlow0_reg <= bus_i.wdata;
      end else if (bus_i.addr == pia_pkg::OFF_FVHIGH0) begin
        fvhigh0_reg <= bus_i.wdata & pia_pkg::FVHIGH_MASK;
      end else if (bus_i.addr == pia_pkg::OFF_FMATCH1) begin
        fmatch1_reg <= bus_i.wdata & pia_pkg::FMATCH_MASK;
      end else if (bus_i.addr == pia_pkg::OFF_FVLOW1) begin
        fvlow1_reg <= bus_i.wdata;
      end else if (bus_i.addr == pia_pkg::OFF_FVHIGH1) begin
        fvhigh1_reg <= bus_i.wdata & pia_pkg::FVHIGH_MASK;
      end else if (bus_i.addr == pia_pkg::OFF_CTRL) begin
        edge_sel_reg <= bus_i.wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, mode and boot sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 16'h0000;
      state_reg <= pia_pkg::ST_BOOT;
      boot_reg  <= 1'b1;
      mode_reg  <= pia_pkg::MODE_FUNC;
    end else begin
      rdata_reg <= bus_i.rd ? rd_mux : rdata_reg;
      state_reg <= pia_pkg::ST_RUN;
      boot_reg  <= 1'b0;
      mode_reg  <= low_power_i ? pia_pkg::MODE_LOWPWR : pia_pkg::MODE_FUNC;
    end
  end

  // ----------------------------------------------------------------
  // core request, vector and wake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg      <= 1'b0;
      fast_reg     <= 1'b0;
      vec_reg      <= pia_pkg::INIT_ADDR;
      pres_lvl_reg <= 2'h0;
      pres_src_reg <= 7'h00;
      wake_reg     <= 1'b0;
      ind_reg      <= 2'h0;
    end else begin
      irq_reg      <= permit && (state_reg == pia_pkg::ST_RUN);
      fast_reg     <= permit && fast_hit && (state_reg == pia_pkg::ST_RUN);
      vec_reg      <= vec_next;
      pres_lvl_reg <= permit ? top_lvl : pres_lvl_reg;
      pres_src_reg <= permit ? win_src : pres_src_reg;
      wake_reg     <= wake_next;
      ind_reg      <= ind_next;
    end
  end

  // ----------------------------------------------------------------
  // external edge detectors
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_a_prev_reg <= 1'b1;
      ext_b_prev_reg <= 1'b1;
      ext_a_lat_reg  <= 1'b0;
      ext_b_lat_reg  <= 1'b0;
    end else begin
      ext_a_prev_reg <= ext_irq_a_n_i;
      ext_b_prev_reg <= ext_irq_b_n_i;
      ext_a_lat_reg  <= ext_a_lat_next;
      ext_b_lat_reg  <= ext_b_lat_next;
    end
  end

  assign rdata_o     = rdata_reg;
  assign core_irq_o  = irq_reg;
  assign core_fast_o = fast_reg;
  assign core_vec_o  = vec_reg;
  assign boot_o      = boot_reg;
  assign wake_o      = wake_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence sleep_req_s;
    lowpwr && have_any;
  endsequence
  sequence wake_seen_s;
    ##1 wake_o;
  endsequence

  mask_honoured_a: assert property (core_irq_o |-> pres_lvl_reg >= $past(core_mask_i))
    else $error("request raised below core mask");
  fixed_level_a: assert property (src_en[0] && src_lvl[0] == pia_pkg::LVL_FIXED)
    else $error("fixed source level changed");
  lowest_wins_a: assert property (core_irq_o && !core_fast_o |->
      (($past(top_vec) & ((82'h1 << core_vec_o[6:0]) - 82'h1)) == 82'h0))
    else $error("lower numbered request lost");
  vector_concat_a: assert property (core_irq_o && !core_fast_o |->
      core_vec_o[20:7] == $past(vbase_reg[13:0]))
    else $error("vector base not concatenated");
  fast_level_a: assert property (core_fast_o |-> core_irq_o && pres_lvl_reg == 2'h2)
    else $error("fast vector outside level 2");
  wake_req_a: assert property (sleep_req_s |-> wake_seen_s)
    else $error("no wake for pending request");
  wake_only_low_a: assert property (wake_o |-> $past(lowpwr) && $past(have_any))
    else $error("wake outside low power");
  ext_level_a: assert property (lowpwr && !ext_irq_a_n_i |->
      req[pia_pkg::SRC_EXT_A])
    else $error("external request not level sensed");
  ext_level_b_a: assert property (lowpwr && !ext_irq_b_n_i |->
      req[pia_pkg::SRC_EXT_B])
    else $error("external request b not level sensed");
  boot_addr_a: assert property (boot_o |-> core_vec_o == pia_pkg::INIT_ADDR && !core_irq_o)
    else $error("initial address not driven");
  prio0_rsvd_a: assert property (
      (prio_reg[0] & ~pia_pkg::PRIO0_MASK) == 16'h0000)
    else $error("reserved priority bits set");

endmodule
`default_nettype wire

// >>> hw/pia_pkg.sv
`default_nettype none
package pia_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC   = 82;
  localparam int SRC_W     = 7;
  localparam int DATA_W    = 16;
  localparam int RAW_W     = 5;
  localparam int VADDR_W   = 21;
  localparam int NUM_PRIO  = 10;
  localparam int NUM_PEND  = 6;

  // ----------------------------------------------------------------
  // register offsets (word offsets from the module base)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_PRIO_FIRST = 5'h00;
  localparam logic [4:0] OFF_PRIO_LAST  = 5'h09;
  localparam logic [4:0] OFF_VBASE      = 5'h0a;
  localparam logic [4:0] OFF_FMATCH0    = 5'h0b;
  localparam logic [4:0] OFF_FVLOW0     = 5'h0c;
  localparam logic [4:0] OFF_FVHIGH0    = 5'h0d;
  localparam logic [4:0] OFF_FMATCH1    = 5'h0e;
  localparam logic [4:0] OFF_FVLOW1     = 5'h0f;
  localparam logic [4:0] OFF_FVHIGH1    = 5'h10;
  localparam logic [4:0] OFF_PEND_FIRST = 5'h11;
  localparam logic [4:0] OFF_PEND_LAST  = 5'h16;
  localparam logic [4:0] OFF_CTRL       = 5'h1d;

  // ----------------------------------------------------------------
  // writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PRIO0_MASK = 16'h3c00;
  localparam logic [15:0] PRIO1_MASK = 16'h003f;
  localparam logic [15:0] PRIO2_MASK = 16'hffcf;
  localparam logic [15:0] PRIO_MASK  = 16'hffff;
  localparam logic [15:0] VBASE_MASK = 16'h3fff;
  localparam logic [15:0] FMATCH_MASK = 16'h007f;
  localparam logic [15:0] FVHIGH_MASK = 16'h001f;
  localparam logic [15:0] CTRL_WMASK = 16'h0003;
  localparam logic [15:0] REG_RST    = 16'h0000;
  localparam logic [20:0] INIT_ADDR  = 21'h0_0000;

  // ----------------------------------------------------------------
  // source groups, levels and control fields
  // ----------------------------------------------------------------
  localparam int FIXED_SRC    = 13;
  localparam int SRC_SOFT_LOW = 12;
  localparam int DBG_FIRST    = 13;
  localparam int GEN_FIRST    = 18;
  localparam int SRC_EXT_A    = 18;
  localparam int SRC_EXT_B    = 19;
  localparam logic [1:0] LVL_FIXED = 2'h3;
  localparam logic [1:0] LVL_SOFT  = 2'h0;
  localparam logic [1:0] LVL_FAST  = 2'h2;
  localparam int CTRL_EDGE_A  = 0;
  localparam int CTRL_EDGE_B  = 1;
  localparam int CTRL_IND_LSB = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pia_bus_t;

  typedef enum logic {ST_BOOT, ST_RUN} pia_state_t;
  typedef enum logic {MODE_FUNC, MODE_LOWPWR} pia_mode_t;
endpackage
`default_nettype wire

// >>> verif/pia_core_model.sv
`default_nettype none
module pia_core_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // arbiter outputs and bench command
  input  wire logic        core_irq_i,
  input  wire logic        core_fast_i,
  input  wire logic [20:0] core_vec_i,
  input  wire logic        take_i,
  input  wire logic [3:0]  lat_i,
  // core answers
  output logic             core_ack_o,
  output logic             core_rti_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  cnt_reg;
  logic [20:0] fetch_reg;
  logic        fast_reg;

  // take a request lat_i cycles after it is seen, return twelve cycles later
  always_ff @(posedge clk_i) begin
    core_ack_o <= 1'b0;
    core_rti_o <= 1'b0;
    if (rst_i) begin
      cnt_reg <= 5'h00;
    end else if (cnt_reg == 5'h00) begin
      cnt_reg <= {4'h0, take_i & core_irq_i};
    end else if (cnt_reg == {1'b0, lat_i} + 5'h0c) begin
      core_rti_o <= 1'b1;
      cnt_reg    <= 5'h00;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
    end
    // fetch at the presented vector; the fetched word is never a subroutine jump
    if (!rst_i && cnt_reg == {1'b0, lat_i}) begin
      core_ack_o <= 1'b1;
      fetch_reg  <= core_vec_i;
      fast_reg   <= core_fast_i;
    end
  end
endmodule
`default_nettype wire

// >>> verif/priority_interrupt_arbiter_test.sv
`default_nettype none
module priority_interrupt_arbiter_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus, observation and notes
  // ----------------------------------------------------------------
  logic              clk_i   = 1'b0;
  logic              rst_i   = 1'b1;
  pia_pkg::pia_bus_t bus     = '0;
  logic [81:0]       src     = '0;
  logic              ext_a_n = 1'b1;
  logic              ext_b_n = 1'b1;
  logic [1:0]        mask    = 2'h0;
  logic              lp      = 1'b0;
  logic              take    = 1'b0;
  logic [3:0]        lat     = 4'h1;
  logic              smp_req = 1'b0;
  logic              rd_seen = 1'b0;
  logic              ack, rti, irq, fast, boot, wake, e_irq;
  logic [15:0]       rdata, d, lo, hi;
  logic [20:0]       vec, last;
  logic [13:0]       b;
  logic [1:0]        lvl;
  logic [15:0]       rd_q[$];
  logic [23:0]       out_q[$];
  int                a, c, m, k, n, sv;
  int                err_total   = 0;
  int                check_count = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  pia_irq_arbiter u_pia_irq_arbiter (
    .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .irq_src_i(src), .ext_irq_a_n_i(ext_a_n), .ext_irq_b_n_i(ext_b_n),
    .core_mask_i(mask), .core_ack_i(ack), .core_rti_i(rti),
    .core_irq_o(irq), .core_fast_o(fast), .core_vec_o(vec), .boot_o(boot),
    .low_power_i(lp), .wake_o(wake));

  pia_core_model u_pia_core_model (
    .clk_i(clk_i), .rst_i(rst_i), .core_irq_i(irq), .core_fast_i(fast),
    .core_vec_i(vec), .take_i(take), .lat_i(lat), .core_ack_o(ack), .core_rti_o(rti));

  // ----------------------------------------------------------------
  // compare, bus and sampling tasks
  // ----------------------------------------------------------------
  task automatic cmp_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_out(input string nm, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus_op(input logic w, input logic r, input logic [4:0] ad, input logic [15:0] wd);
    @(posedge clk_i);
    bus <= '{wr: w, rd: r, addr: ad, wdata: wd};
    @(posedge clk_i);
    bus <= '0;
  endtask

  task automatic wr(input logic [4:0] ad, input logic [15:0] wd);
    bus_op(1'b1, 1'b0, ad, wd);
  endtask
  task automatic rd(input logic [4:0] ad, input logic [15:0] e);
    rd_q.push_back(e);
    bus_op(1'b0, 1'b1, ad, 16'h0000);
  endtask
  task automatic setin(input logic [81:0] s, input logic [1:0] mk);
    @(posedge clk_i);
    src  <= s;
    mask <= mk;
  endtask

  // note {irq, fast, vector, wake} and have the monitor look one edge later
  task automatic smp(input logic [23:0] e);
    repeat (3) @(posedge clk_i);
    out_q.push_back(e);
    smp_req <= 1'b1;
    @(posedge clk_i);
    smp_req <= 1'b0;
  endtask

  function automatic logic [15:0] wmask(input logic [4:0] ad);
    case (ad)
      5'h00: return pia_pkg::PRIO0_MASK;
      5'h01: return pia_pkg::PRIO1_MASK;
      5'h02: return pia_pkg::PRIO2_MASK;
      5'h0a: return pia_pkg::VBASE_MASK;
      5'h0b, 5'h0e: return pia_pkg::FMATCH_MASK;
      5'h0d, 5'h10: return pia_pkg::FVHIGH_MASK;
      5'h1d: return pia_pkg::CTRL_WMASK;
      default: return (ad < 5'h11) ? 16'hffff : 16'h0000;
    endcase
  endfunction

  task automatic complete_run();
    if (rd_q.size() + out_q.size() != 0) err_total++;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // monitor: each result is compared with the oldest note
  always @(posedge clk_i) begin
    if (rd_seen) cmp_reg("rdata", rd_q.pop_front(), rdata);
    if (smp_req) cmp_out("outputs", out_q.pop_front(), {irq, fast, vec, wake});
    rd_seen <= bus.rd;
  end

  // watchdog cuts a hang short
  initial begin
    #200us;
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(83));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 cmp_out("boot", {3'h1, 21'h0}, {3'(boot), vec});
    repeat (2) @(posedge clk_i);
    #1 cmp_out("boot", 24'h0, {23'h0, boot});
    // reset values, writable bits, read-only and unmapped places
    for (a = 0; a < 32; a++) begin
      d = 16'($urandom);
      rd(5'(a), 16'h0000);
      wr(5'(a), d);
      rd(5'(a), d & wmask(5'(a)));
    end
    for (a = 0; a < 32; a++) wr(5'(a), 16'h0000);
    b = 14'($urandom);
    wr(5'h0a, {2'b00, b});
    // fixed sources, lowest number wins, mask
    setin((82'(1) << 5) | (82'(1) << 3), 2'h3);
    last = {b, 7'd3};
    smp({2'b10, last, 1'b0});
    setin(82'(1) << 12, 2'h1);
    smp({2'b00, last, 1'b0});
    setin(82'(1) << 12, 2'h0);
    last = {b, 7'd12};
    smp({2'b10, last, 1'b0});
    // every field code against every mask, debug and peripheral groups
    for (k = 0; k < 2; k++) begin
      sv = k ? 30 : 13;
      for (c = 0; c < 4; c++) begin
        wr(k ? 5'h03 : 5'h00, 16'(c) << (k ? 8 : 12));
        lvl = 2'(k ? c - 1 : c);
        for (m = 0; m < 4; m++) begin
          setin(82'(1) << sv, 2'(m));
          e_irq = (c != 0) && (lvl >= 2'(m));
          if (e_irq) last = {b, 7'(sv)};
          smp({e_irq, 1'b0, last, 1'b0});
        end
      end
    end
    // fast slots: slot 1, then slot 0 wins, then level 1 is not fast
    lo = 16'($urandom);
    hi = 16'($urandom);
    wr(5'h0e, 16'd30);
    wr(5'h0f, lo);
    wr(5'h10, hi);
    setin(82'(1) << 30, 2'h0);
    smp({2'b11, hi[4:0], lo, 1'b0});
    d = 16'($urandom);
    wr(5'h0b, 16'd30);
    wr(5'h0c, d);
    wr(5'h0d, ~hi);
    last = {~hi[4:0], d};
    smp({2'b11, last, 1'b0});
    rd(5'h12, 16'h4000);
    wr(5'h03, 16'h0200);
    smp({2'b10, b, 7'd30, 1'b0});
    wr(5'h03, 16'h0300);
    // level indication follows take and return
    @(posedge clk_i);
    take <= 1'b1;
    lat  <= 4'($urandom_range(1, 6));
    n = 0;
    do @(posedge clk_i); while (!ack && ++n < 40);
    take <= 1'b0;
    cmp_out("ack", 24'h1, {23'h0, ack});
    rd(5'h1d, 16'h000c);
    n = 0;
    do @(posedge clk_i); while (!rti && ++n < 40);
    rd(5'h1d, 16'h0000);
    // wake from low power: disabled source stays asleep, external A level wakes
    wr(5'h1d, 16'h0003);
    wr(5'h02, 16'h0005);
    setin(82'h0, 2'h3);
    @(posedge clk_i);
    lp <= 1'b1;
    setin(82'(1) << 31, 2'h3);
    smp({2'b00, last, 1'b0});
    ext_b_n <= 1'b0;
    smp({2'b00, last, 1'b1});
    ext_b_n <= 1'b1;
    ext_a_n <= 1'b0;
    smp({2'b00, last, 1'b1});
    repeat (3) @(posedge clk_i);
    complete_run();
  end
endmodule
`default_nettype wire
